/* shared/dap_pkg.sv */
// Shared constants, types and helpers for the scan and debug access port
package dap_pkg;

  // ==========================================================================
  // Instructions
  typedef logic [3:0] ir_t;
  localparam ir_t IR_EXTEST = 4'h0;
  localparam ir_t IR_SAMPLE = 4'h1;
  localparam ir_t IR_IDENT = 4'h2;
  localparam ir_t IR_USER = 4'h3;
  localparam ir_t IR_TILE = 4'h8;
  localparam ir_t IR_OTP = 4'h9;
  localparam ir_t IR_DBG = 4'hA;
  localparam ir_t IR_BYPASS = 4'hF;
  localparam ir_t IR_CAP_PAT = 4'h1;

  // ==========================================================================
  // Identification, all values arbitrary
  localparam logic [3:0] ID_VERSION = 4'h1;
  localparam logic [15:0] BS_PART = 16'h0B51;
  localparam logic [15:0] CHIP_PART = 16'h0C71;
  localparam logic [10:0] ID_MFR = 11'h2A5;
  localparam logic [7:0] SI_REV = 8'h01;

  // ==========================================================================
  // Field positions and widths
  localparam int WORD_W = 32;
  localparam int UID_W = 10;
  localparam int UID_LSB = 22;
  localparam int USER_GAP_W = 14;
  localparam int SEC_JTAG_OFF = 0;
  localparam int SEC_OTP_OFF = 13;
  localparam int SEC_DBG_OFF = 14;
  localparam int BS_W = 8;
  localparam int BOOT_W = 3;
  localparam int LEN_ONE = 1;
  localparam int SEC_SYNC_W = UID_W + 2;
  localparam int LVL_SYNC_W = BOOT_W + 2;

  // ==========================================================================
  // Timing
  localparam int CLK_NS = 10;
  localparam int TRST_MIN_NS = 100;
  localparam int TRST_MIN_CYC = (TRST_MIN_NS + CLK_NS - 1) / CLK_NS;

  // ==========================================================================
  // Access kinds and carriers
  typedef logic [1:0] kind_t;
  localparam kind_t KIND_TILE = 2'h0;
  localparam kind_t KIND_OTP = 2'h1;
  localparam kind_t KIND_DBG = 2'h2;

  typedef struct packed {kind_t kind; logic [WORD_W-1:0] word;} cmd_t;
  typedef struct packed {logic tile; logic otp; logic dbg; logic [WORD_W-1:0] word;} acc_req_t;
  typedef struct packed {logic cap_dr; logic sh_dr; logic upd_dr; logic sh_ir;} tap_ctl_t;

  // ==========================================================================
  // Controller states
  typedef enum logic [15:0] {
    TS_RESET = 16'h0001, TS_IDLE = 16'h0002, TS_SEL_DR = 16'h0004, TS_CAP_DR = 16'h0008,
    TS_SH_DR = 16'h0010, TS_EX1_DR = 16'h0020, TS_PAU_DR = 16'h0040, TS_EX2_DR = 16'h0080,
    TS_UPD_DR = 16'h0100, TS_SEL_IR = 16'h0200, TS_CAP_IR = 16'h0400, TS_SH_IR = 16'h0800,
    TS_EX1_IR = 16'h1000, TS_PAU_IR = 16'h2000, TS_EX2_IR = 16'h4000, TS_UPD_IR = 16'h8000
  } tap_state_t;
  typedef enum logic [1:0] {BOOT_WAIT = 2'h1, BOOT_RUN = 2'h2} boot_st_t;

  typedef struct packed {tap_state_t st; ir_t ir_sh; ir_t ir;} tap_st_t;
  typedef struct packed {logic tdo; logic oe;} tdo_st_t;
  typedef struct packed {
    boot_st_t boot; logic [BOOT_W-1:0] mode; logic boot_start; logic req_seen; logic ack_tgl;
    logic wait_tile; logic wait_otp; logic dbg_prev; logic bkpt; logic drv;
    acc_req_t acc; logic [WORD_W-1:0] resp;
  } clk_st_t;
  typedef struct packed {
    logic [WORD_W-1:0] dr_b; logic [WORD_W-1:0] dr_c; logic [BS_W-1:0] bsr_upd;
    logic extest; logic req_tgl; cmd_t cmd;
  } tck_st_t;

  localparam tap_st_t TAP_ST_RST = '{st: TS_RESET, ir_sh: IR_CAP_PAT, ir: IR_IDENT};
  localparam tdo_st_t TDO_ST_RST = '0;
  localparam clk_st_t CLK_ST_RST = '{boot: BOOT_WAIT, dbg_prev: 1'b1, default: '0};
  localparam tck_st_t TCK_ST_RST = '0;
  localparam logic [LVL_SYNC_W-1:0] LVL_SYNC_RST = 5'h10;
  localparam logic [SEC_SYNC_W-1:0] SEC_SYNC_RST = 12'h000;

  // ==========================================================================
  // Helpers
  function automatic logic [WORD_W-1:0] id_word(input logic [15:0] part);
    return {ID_VERSION, part, ID_MFR, 1'b1};
  endfunction

  function automatic logic [WORD_W-1:0] user_word(input logic [UID_W-1:0] uid);
    return {uid, {USER_GAP_W{1'b0}}, SI_REV};
  endfunction

  // Shift towards bit 0 with the new bit entering at the top of the active length
  function automatic logic [WORD_W-1:0] dr_shift(input logic [WORD_W-1:0] d, input logic b, input int len);
    logic [WORD_W-1:0] s;
    s = d >> 1;
    s[len-1] = b;
    return s;
  endfunction

endpackage

/* design/dap_sync3.sv */
// Three-stage level synchroniser with an agreement filter
module dap_sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] RSTV = '0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_st_t;

  sync_st_t s_r;
  sync_st_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.s1 = d_i;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    // Stage one is metastable-prone, so only stages two and three are compared
    if (s_r.s2 == s_r.s3) begin
      s_nxt.q = s_r.s3;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= {4{RSTV}};
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  assign q_o = s_r.q;

endmodule

/* design/dap_tap.sv */
// Test access port controller with instruction register and falling-edge data out
module dap_tap (
  input wire logic tck_i,
  input wire logic trst_n_i,
  input wire logic hold_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic dr_tdo_i,
  output dap_pkg::tap_ctl_t ctl_o,
  output dap_pkg::ir_t ir_o,
  output logic tdo_o,
  output logic tdo_oe_o
);

  dap_pkg::tap_st_t s_r;
  dap_pkg::tap_st_t s_nxt;
  dap_pkg::tdo_st_t o_r;
  dap_pkg::tdo_st_t o_nxt;

  // ==========================================================================
  // State walk
  always_comb begin
    s_nxt = s_r;
    case (s_r.st)
      dap_pkg::TS_RESET: s_nxt.st = tms_i ? dap_pkg::TS_RESET : dap_pkg::TS_IDLE;
      dap_pkg::TS_IDLE: s_nxt.st = tms_i ? dap_pkg::TS_SEL_DR : dap_pkg::TS_IDLE;
      dap_pkg::TS_SEL_DR: s_nxt.st = tms_i ? dap_pkg::TS_SEL_IR : dap_pkg::TS_CAP_DR;
      dap_pkg::TS_CAP_DR: s_nxt.st = tms_i ? dap_pkg::TS_EX1_DR : dap_pkg::TS_SH_DR;
      dap_pkg::TS_SH_DR: s_nxt.st = tms_i ? dap_pkg::TS_EX1_DR : dap_pkg::TS_SH_DR;
      dap_pkg::TS_EX1_DR: s_nxt.st = tms_i ? dap_pkg::TS_UPD_DR : dap_pkg::TS_PAU_DR;
      dap_pkg::TS_PAU_DR: s_nxt.st = tms_i ? dap_pkg::TS_EX2_DR : dap_pkg::TS_PAU_DR;
      dap_pkg::TS_EX2_DR: s_nxt.st = tms_i ? dap_pkg::TS_UPD_DR : dap_pkg::TS_SH_DR;
      dap_pkg::TS_UPD_DR: s_nxt.st = tms_i ? dap_pkg::TS_SEL_DR : dap_pkg::TS_IDLE;
      dap_pkg::TS_SEL_IR: s_nxt.st = tms_i ? dap_pkg::TS_RESET : dap_pkg::TS_CAP_IR;
      dap_pkg::TS_CAP_IR: s_nxt.st = tms_i ? dap_pkg::TS_EX1_IR : dap_pkg::TS_SH_IR;
      dap_pkg::TS_SH_IR: s_nxt.st = tms_i ? dap_pkg::TS_EX1_IR : dap_pkg::TS_SH_IR;
      dap_pkg::TS_EX1_IR: s_nxt.st = tms_i ? dap_pkg::TS_UPD_IR : dap_pkg::TS_PAU_IR;
      dap_pkg::TS_PAU_IR: s_nxt.st = tms_i ? dap_pkg::TS_EX2_IR : dap_pkg::TS_PAU_IR;
      dap_pkg::TS_EX2_IR: s_nxt.st = tms_i ? dap_pkg::TS_UPD_IR : dap_pkg::TS_SH_IR;
      dap_pkg::TS_UPD_IR: s_nxt.st = tms_i ? dap_pkg::TS_SEL_DR : dap_pkg::TS_IDLE;
      default: s_nxt.st = dap_pkg::TS_RESET;
    endcase
    if (s_r.st == dap_pkg::TS_CAP_IR) begin
      s_nxt.ir_sh = dap_pkg::IR_CAP_PAT;
    end else if (s_r.st == dap_pkg::TS_SH_IR) begin
      s_nxt.ir_sh = {tdi_i, s_r.ir_sh[3:1]};
    end
    if (s_r.st == dap_pkg::TS_UPD_IR) begin
      s_nxt.ir = s_r.ir_sh;
    end
    if (s_r.st == dap_pkg::TS_RESET) begin
      s_nxt.ir = dap_pkg::IR_IDENT;
    end
    if (hold_i) begin
      s_nxt = dap_pkg::TAP_ST_RST;
    end
  end

  // Output changes on the falling edge so the next stage samples it cleanly
  always_comb begin
    o_nxt.oe = (s_r.st == dap_pkg::TS_SH_DR) || (s_r.st == dap_pkg::TS_SH_IR);
    o_nxt.tdo = (s_r.st == dap_pkg::TS_SH_IR) ? s_r.ir_sh[0] : dr_tdo_i;
  end

  always_ff @(posedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      s_r <= dap_pkg::TAP_ST_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_ff @(negedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      o_r <= dap_pkg::TDO_ST_RST;
    end else begin
      o_r <= o_nxt;
    end
  end

  assign ctl_o.cap_dr = (s_r.st == dap_pkg::TS_CAP_DR);
  assign ctl_o.sh_dr = (s_r.st == dap_pkg::TS_SH_DR);
  assign ctl_o.upd_dr = (s_r.st == dap_pkg::TS_UPD_DR);
  assign ctl_o.sh_ir = (s_r.st == dap_pkg::TS_SH_IR);
  assign ir_o = s_r.ir;
  assign tdo_o = o_r.tdo;
  assign tdo_oe_o = o_r.oe;

endmodule

/* design/jtag_debug_access_port.sv */
// Scan and debug access port of one tile: two chained controllers, debug pin, reset and boot start
//
// Behaviour
// RL1: After reset the chain holds two controllers per tile, boundary scan first and then chip access.
// RL2: The boundary controller follows the standard scan protocol and samples and drives the tile pins.
// RL3: The chip controller lets the host reach the tile, the switch and the one-time memory; the code has no switch access.
// RL4: The host holds the test reset low at power-up and 100 ns after, and low test reset resets all scan logic; clock-side access state needs chip reset.
// RL5: The debug pin works both ways and software chooses how the tile reacts to it.
// RL6: As an output the debug pin floats until a breakpoint is hit and is then driven low.
// RL7: As an input a low level driven from outside puts the tile into debug mode.
// RL8: The identification instruction shifts out a 32-bit word of version, part, maker and a one in bit 0.
// RL9: The user-code instruction shifts out the user identifier, an unused span and the silicon revision.
// RL10: The user identifier comes from security bits 31 to 22 and reads zero when unprogrammed.
// RL11: The active-low chip reset resets the whole device and takes effect without a clock; the code leaves the test-clock logic to test reset.
// RL12: After chip reset release the device waits for PLL lock and only then starts booting.
// RL13: Security bit 0 disables the scan interface completely.
// RL14: Security bit 13 blocks all scan reads and writes of the one-time memory.
// RL15: Security bit 14 disables all use of the debug pin.
// RL16: The identification word has version 31..28, part 27..12 and maker 11..1.
// RL17: Chip reset release is synchronous to the reference clock.
module jtag_debug_access_port (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic pll_lock_i,
  input wire logic [dap_pkg::BOOT_W-1:0] boot_mode_i,
  output logic boot_start_o,
  output logic booting_o,
  output logic [dap_pkg::BOOT_W-1:0] boot_mode_o,
  input wire logic [dap_pkg::WORD_W-1:0] sec_reg_i,
  input wire logic tck_i,
  input wire logic trst_n_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  input wire logic [dap_pkg::BS_W-1:0] pad_level_i,
  output logic [dap_pkg::BS_W-1:0] pad_drive_o,
  output logic pad_extest_o,
  input wire logic debug_n_i,
  output logic debug_n_o,
  output logic debug_n_oe_o,
  input wire logic dbg_out_en_i,
  input wire logic dbg_in_en_i,
  input wire logic bkpt_i,
  input wire logic bkpt_clr_i,
  output dap_pkg::acc_req_t acc_o,
  input wire logic tile_rvalid_i,
  input wire logic [dap_pkg::WORD_W-1:0] tile_rdata_i,
  input wire logic otp_rvalid_i,
  input wire logic [dap_pkg::WORD_W-1:0] otp_rdata_i
);

  // ==========================================================================
  // Declarations
  logic srst_n;
  logic [dap_pkg::LVL_SYNC_W-1:0] lvl_s;
  logic req_s;
  logic ack_s;
  logic [dap_pkg::SEC_SYNC_W-1:0] sec_s;
  logic [dap_pkg::BS_W-1:0] pad_s;
  logic lock_s;
  logic dbg_pin_s;
  logic [dap_pkg::BOOT_W-1:0] mode_s;
  logic jtag_off_s;
  logic otp_off_s;
  logic [dap_pkg::UID_W-1:0] uid_s;
  logic dbg_off;
  logic busy;
  dap_pkg::tap_ctl_t ctl_b;
  dap_pkg::tap_ctl_t ctl_c;
  dap_pkg::ir_t ir_b;
  dap_pkg::ir_t ir_c;
  logic tdo_b;
  logic [dap_pkg::WORD_W-1:0] cap_b;
  logic [dap_pkg::WORD_W-1:0] cap_c;
  int len_b;
  int len_c;
  logic acc_ok;
  dap_pkg::kind_t acc_kind;
  dap_pkg::clk_st_t c_r;
  dap_pkg::clk_st_t c_nxt;
  dap_pkg::tck_st_t t_r;
  dap_pkg::tck_st_t t_nxt;

  // ==========================================================================
  // Reset and level synchronisers on the reference clock
  // Assertion is immediate, release waits for the clock
  dap_sync3 #(
    .W(1),
    .RSTV(1'b0)
  ) u_rst_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .d_i(1'b1),
    .q_o(srst_n)
  ); // RL11 RL17

  dap_sync3 #(
    .W(dap_pkg::LVL_SYNC_W),
    .RSTV(dap_pkg::LVL_SYNC_RST)
  ) u_lvl_sync (
    .clk_i(clk_i),
    .rst_n_i(srst_n),
    .ce_i(ce_i),
    .d_i({debug_n_i, boot_mode_i, pll_lock_i}),
    .q_o(lvl_s)
  );

  dap_sync3 #(
    .W(1),
    .RSTV(1'b0)
  ) u_req_sync (
    .clk_i(clk_i),
    .rst_n_i(srst_n),
    .ce_i(ce_i),
    .d_i(t_r.req_tgl),
    .q_o(req_s)
  );

  assign lock_s = lvl_s[0];
  assign mode_s = lvl_s[dap_pkg::BOOT_W:1];
  assign dbg_pin_s = lvl_s[dap_pkg::LVL_SYNC_W-1];
  assign dbg_off = sec_reg_i[dap_pkg::SEC_DBG_OFF];

  // ==========================================================================
  // Synchronisers on the test clock
  dap_sync3 #(
    .W(1),
    .RSTV(1'b0)
  ) u_ack_sync (
    .clk_i(tck_i),
    .rst_n_i(trst_n_i),
    .ce_i(1'b1),
    .d_i(c_r.ack_tgl),
    .q_o(ack_s)
  );

  // Security bits are static after power-up; a brief lag after test reset is harmless
  dap_sync3 #(
    .W(dap_pkg::SEC_SYNC_W),
    .RSTV(dap_pkg::SEC_SYNC_RST)
  ) u_sec_sync (
    .clk_i(tck_i),
    .rst_n_i(trst_n_i),
    .ce_i(1'b1),
    .d_i({sec_reg_i[dap_pkg::UID_LSB +: dap_pkg::UID_W], sec_reg_i[dap_pkg::SEC_OTP_OFF],
      sec_reg_i[dap_pkg::SEC_JTAG_OFF]}),
    .q_o(sec_s)
  );

  dap_sync3 #(
    .W(dap_pkg::BS_W),
    .RSTV('0)
  ) u_pad_sync (
    .clk_i(tck_i),
    .rst_n_i(trst_n_i),
    .ce_i(1'b1),
    .d_i(pad_level_i),
    .q_o(pad_s)
  );

  assign jtag_off_s = sec_s[0];
  assign otp_off_s = sec_s[1];
  assign uid_s = sec_s[dap_pkg::SEC_SYNC_W-1:2];
  assign busy = (t_r.req_tgl != ack_s);

  // ==========================================================================
  // Controllers: boundary scan first in the chain, chip access second
  dap_tap u_tap_bs (
    .tck_i(tck_i),
    .trst_n_i(trst_n_i),
    .hold_i(jtag_off_s),
    .tms_i(tms_i),
    .tdi_i(tdi_i),
    .dr_tdo_i(t_r.dr_b[0]),
    .ctl_o(ctl_b),
    .ir_o(ir_b),
    .tdo_o(tdo_b),
    .tdo_oe_o()
  ); // RL1 RL13

  dap_tap u_tap_chip (
    .tck_i(tck_i),
    .trst_n_i(trst_n_i),
    .hold_i(jtag_off_s),
    .tms_i(tms_i),
    .tdi_i(tdo_b),
    .dr_tdo_i(t_r.dr_c[0]),
    .ctl_o(ctl_c),
    .ir_o(ir_c),
    .tdo_o(tdo_o),
    .tdo_oe_o(tdo_oe_o)
  ); // RL1 RL13

  // ==========================================================================
  // Data registers on the test clock
  always_comb begin
    t_nxt = t_r;
    cap_b = '0;
    len_b = dap_pkg::LEN_ONE;
    cap_c = '0;
    len_c = dap_pkg::LEN_ONE;
    acc_ok = 1'b0;
    acc_kind = dap_pkg::KIND_DBG;
    case (ir_b)
      dap_pkg::IR_IDENT: begin
        cap_b = dap_pkg::id_word(dap_pkg::BS_PART); // RL8 RL16
        len_b = dap_pkg::WORD_W;
      end
      dap_pkg::IR_SAMPLE, dap_pkg::IR_EXTEST: begin
        cap_b[dap_pkg::BS_W-1:0] = pad_s; // RL2
        len_b = dap_pkg::BS_W;
      end
      default: begin
        len_b = dap_pkg::LEN_ONE;
      end
    endcase
    case (ir_c)
      dap_pkg::IR_IDENT: begin
        cap_c = dap_pkg::id_word(dap_pkg::CHIP_PART); // RL8 RL16
        len_c = dap_pkg::WORD_W;
      end
      dap_pkg::IR_USER: begin
        cap_c = dap_pkg::user_word(uid_s); // RL9 RL10
        len_c = dap_pkg::WORD_W;
      end
      dap_pkg::IR_TILE: begin
        cap_c = busy ? '0 : c_r.resp; // RL3
        len_c = dap_pkg::WORD_W;
        acc_ok = 1'b1;
        acc_kind = dap_pkg::KIND_TILE;
      end
      dap_pkg::IR_OTP: begin
        cap_c = (busy || otp_off_s) ? '0 : c_r.resp; // RL14
        len_c = dap_pkg::WORD_W;
        acc_ok = !otp_off_s; // RL14
        acc_kind = dap_pkg::KIND_OTP;
      end
      dap_pkg::IR_DBG: begin
        acc_ok = 1'b1;
        acc_kind = dap_pkg::KIND_DBG;
      end
      default: begin
        len_c = dap_pkg::LEN_ONE;
      end
    endcase
    if (ctl_b.cap_dr) begin
      t_nxt.dr_b = cap_b;
    end else if (ctl_b.sh_dr) begin
      t_nxt.dr_b = dap_pkg::dr_shift(t_r.dr_b, tdi_i, len_b);
    end
    if (ctl_b.upd_dr && (ir_b == dap_pkg::IR_SAMPLE || ir_b == dap_pkg::IR_EXTEST)) begin
      t_nxt.bsr_upd = t_r.dr_b[dap_pkg::BS_W-1:0]; // RL2
    end
    t_nxt.extest = (ir_b == dap_pkg::IR_EXTEST); // RL2
    if (ctl_c.cap_dr) begin
      t_nxt.dr_c = cap_c;
    end else if (ctl_c.sh_dr) begin
      t_nxt.dr_c = dap_pkg::dr_shift(t_r.dr_c, tdo_b, len_c);
    end
    // Word stays put until the far side has acknowledged, so a new update while busy is dropped
    if (ctl_c.upd_dr && acc_ok && !busy) begin
      t_nxt.cmd.kind = acc_kind; // RL3
      t_nxt.cmd.word = t_r.dr_c;
      t_nxt.req_tgl = ~t_r.req_tgl;
    end
  end

  always_ff @(posedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      t_r <= dap_pkg::TCK_ST_RST; // RL4
    end else begin
      t_r <= t_nxt;
    end
  end

  // ==========================================================================
  // Boot start, access requests and debug pin on the reference clock
  always_comb begin
    c_nxt = c_r;
    c_nxt.boot_start = 1'b0;
    c_nxt.acc.tile = 1'b0;
    c_nxt.acc.otp = 1'b0;
    c_nxt.acc.dbg = 1'b0;
    case (c_r.boot)
      dap_pkg::BOOT_WAIT: begin
        c_nxt.mode = mode_s;
        if (lock_s) begin
          c_nxt.boot = dap_pkg::BOOT_RUN; // RL12
          c_nxt.boot_start = 1'b1;
        end
      end
      dap_pkg::BOOT_RUN: begin
        c_nxt.boot = dap_pkg::BOOT_RUN;
      end
      default: begin
        c_nxt.boot = dap_pkg::BOOT_WAIT;
      end
    endcase
    if (req_s != c_r.req_seen) begin
      c_nxt.req_seen = req_s;
      c_nxt.acc.word = t_r.cmd.word; // RL3
      case (t_r.cmd.kind)
        dap_pkg::KIND_TILE: begin
          c_nxt.acc.tile = 1'b1;
          c_nxt.wait_tile = 1'b1;
        end
        dap_pkg::KIND_OTP: begin
          c_nxt.acc.otp = 1'b1;
          c_nxt.wait_otp = 1'b1;
        end
        default: begin
          c_nxt.acc.dbg = 1'b1;
          c_nxt.ack_tgl = ~c_r.ack_tgl;
        end
      endcase
    end
    if (c_r.wait_tile && tile_rvalid_i) begin
      c_nxt.resp = tile_rdata_i;
      c_nxt.wait_tile = 1'b0;
      c_nxt.ack_tgl = ~c_r.ack_tgl;
    end else if (c_r.wait_otp && otp_rvalid_i) begin
      c_nxt.resp = otp_rdata_i;
      c_nxt.wait_otp = 1'b0;
      c_nxt.ack_tgl = ~c_r.ack_tgl;
    end
    // Own drive is ignored as input, else one tile would retrigger itself
    c_nxt.dbg_prev = dbg_pin_s;
    if (dbg_in_en_i && !dbg_off && !c_r.drv && c_r.dbg_prev && !dbg_pin_s) begin
      c_nxt.acc.dbg = 1'b1; // RL5 RL7 RL15
    end
    if (bkpt_i) begin
      c_nxt.bkpt = 1'b1;
    end else if (bkpt_clr_i) begin
      c_nxt.bkpt = 1'b0;
    end
    c_nxt.drv = c_nxt.bkpt && dbg_out_en_i && !dbg_off; // RL5 RL6 RL15
  end

  always_ff @(posedge clk_i or negedge srst_n) begin
    if (!srst_n) begin
      c_r <= dap_pkg::CLK_ST_RST; // RL11
    end else if (ce_i) begin
      c_r <= c_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  assign boot_start_o = c_r.boot_start;
  assign booting_o = (c_r.boot == dap_pkg::BOOT_RUN);
  assign boot_mode_o = c_r.mode;
  assign acc_o = c_r.acc;
  assign debug_n_o = 1'b0; // RL6
  assign debug_n_oe_o = c_r.drv; // RL6
  assign pad_drive_o = t_r.bsr_upd;
  assign pad_extest_o = t_r.extest;

endmodule

/* verif/dap_assertions.sv */
// Concurrent checks on the access port pins
module dap_assertions (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic pll_lock_i,
  input wire logic boot_start_o,
  input wire logic booting_o,
  input wire logic [dap_pkg::WORD_W-1:0] sec_reg_i,
  input wire logic tck_i,
  input wire logic trst_n_i,
  input wire logic tdo_oe_o,
  input wire logic [dap_pkg::BS_W-1:0] pad_drive_o,
  input wire logic pad_extest_o,
  input wire logic debug_n_oe_o,
  input wire logic dbg_out_en_i,
  input wire dap_pkg::acc_req_t acc_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==================
  // Checks
  a_boot_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    boot_start_o |=> !boot_start_o && booting_o) else $error("boot pulse");
  a_boot_lock: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    boot_start_o |-> $past(pll_lock_i, 3)) else $error("boot without lock");
  a_boot_stays: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    booting_o |=> booting_o) else $error("booting dropped");
  a_reset_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> !boot_start_o && !booting_o && !debug_n_oe_o && acc_o == '0) else $error("reset");
  // Enable and lockout may pass a synchroniser, hence the margin
  a_pin_cause: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(debug_n_oe_o) |-> $past(dbg_out_en_i) && !$past(sec_reg_i[14])) else $error("pin cause");
  a_pin_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!dbg_out_en_i || sec_reg_i[14]) [*6] |-> !debug_n_oe_o) else $error("pin while off");
  a_trst_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !trst_n_i |-> !tdo_oe_o && pad_drive_o == '0 && !pad_extest_o) else $error("scan not reset");
  a_scan_off: assert property (@(posedge tck_i) disable iff (!trst_n_i)
    sec_reg_i[0] [*6] |-> !tdo_oe_o) else $error("scan while disabled");
  c_boot: cover property (@(posedge clk_i) boot_start_o);
  c_dbg_req: cover property (@(posedge clk_i) acc_o.dbg);
  c_shift: cover property (@(posedge tck_i) tdo_oe_o);
endmodule

/* verif/jtag_host_model.sv */
// Scan host model: the test clock runs only inside frames
module jtag_host_model (
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  output logic trst_n_o,
  input wire logic tdo_i,
  input wire logic tdo_oe_i
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==================
  // Frames
  int oe_seen = 0;
  logic b;
  initial begin
    // Late start so the first low test reset is a real edge for the design
    #1;
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
    trst_n_o = 1'b0;
  end
  task automatic step(input logic tms, input logic tdi);
    tms_o = tms;
    tdi_o = tdi;
    #62.5;
    tck_o = 1'b1;
    b = tdo_i;
    oe_seen += int'(tdo_oe_i);
    #62.5;
    tck_o = 1'b0;
  endtask
  task automatic treset();
    trst_n_o = 1'b0;
    #200;
    trst_n_o = 1'b1;
    repeat (5) step(1'b1, 1'b0);
  endtask
  // Starts in reset or idle and leaves the controllers idle
  task automatic shift(input logic ir, input int n, input logic [63:0] din, output logic [63:0] dout);
    dout = 64'h0;
    for (int i = 0; i < 4 + int'(ir); i++) step(i == 1 || (ir && i == 2), 1'b0);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i]);
      dout[i] = b;
    end
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask
endmodule

/* verif/testbench.sv */
// Self-checking bench for the scan and debug access port
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  // ==================
  // Bench
  logic clk = 1'b0, rst_n = 1'b0, lock = 1'b0, oen = 1'b0, ien = 1'b0, bkpt = 1'b0, bclr = 1'b0, ext_n = 1'b1;
  logic ce = 1'b1;
  logic [2:0] mode;
  logic [7:0] pads = 8'h0;
  logic [31:0] sec = 32'h0;
  logic bs, bt, tck, tms, tdi, trst_n, tdo, toe, pext, dno, doe;
  logic [2:0] bm;
  logic [7:0] pdrv;
  dap_pkg::acc_req_t acc;
  int err_count = 0, cmp_count = 0, dbg_cnt = 0, seed = 32'hA70E;
  // Pull-up holds the pin high unless someone drives it low
  wire pin = doe ? dno : ext_n;
  always #5 clk = ~clk;
  always @(posedge clk) dbg_cnt <= dbg_cnt + int'(acc.dbg);
  jtag_debug_access_port dut_u (.clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .pll_lock_i(lock), .boot_mode_i(mode),
    .boot_start_o(bs), .booting_o(bt), .boot_mode_o(bm), .sec_reg_i(sec), .tck_i(tck), .trst_n_i(trst_n),
    .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(toe), .pad_level_i(pads), .pad_drive_o(pdrv),
    .pad_extest_o(pext), .debug_n_i(pin), .debug_n_o(dno), .debug_n_oe_o(doe), .dbg_out_en_i(oen),
    .dbg_in_en_i(ien), .bkpt_i(bkpt), .bkpt_clr_i(bclr), .acc_o(acc), .tile_rvalid_i(1'b0),
    .tile_rdata_i(32'h0), .otp_rvalid_i(1'b0), .otp_rdata_i(32'h0));
  jtag_host_model host_u (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n), .tdo_i(tdo), .tdo_oe_i(toe));
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("Compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic [31:0] exp_id(input logic [15:0] part);
    return {dap_pkg::ID_VERSION, part, dap_pkg::ID_MFR, 1'b1};
  endfunction
  initial begin
    #200000;
    err_count++;
    stop_test();
  end
  initial begin
    logic [63:0] q;
    logic [9:0] uid;
    int n;
    mode = 3'($random(seed));
    for (int r = 0; r < 2; r++) begin
      tick(2);
      check("booting", bt, 1'b0);
      rst_n = 1'b1;
      pads = 8'($random(seed));
      tick(10);
      check("early boot", bt, 1'b0);
      lock = 1'b1;
      n = 0;
      while (bs !== 1'b1 && n < 12) begin
        tick(1);
        n++;
      end
      check("boot start", bs, 1'b1);
      tick(1);
      check("boot mode", bm, mode);
      if (r == 0) begin
        rst_n = 1'b0;
        lock = 1'b0;
        mode = 3'($random(seed));
      end
    end
    for (int r = 0; r < 2; r++) begin
      uid = r ? 10'h0 : 10'($random(seed));
      sec = {uid, 22'h0};
      host_u.treset();
      host_u.shift(1'b0, 64, 64'h0, q);
      check("id chain", q, {exp_id(dap_pkg::BS_PART), exp_id(dap_pkg::CHIP_PART)});
      host_u.shift(1'b1, 8, {56'h0, dap_pkg::IR_BYPASS, dap_pkg::IR_USER}, q);
      check("ir capture", q, 64'h11);
      host_u.shift(1'b0, 33, 64'h0, q);
      check("user code", q[31:0], {uid, 14'h0, dap_pkg::SI_REV});
    end
    host_u.shift(1'b1, 8, {56'h0, dap_pkg::IR_EXTEST, dap_pkg::IR_BYPASS}, q);
    host_u.shift(1'b0, 9, {55'h0, ~pads, 1'b0}, q);
    check("pad capture", q[8:0], {pads, 1'b0});
    check("pad drive", {pext, pdrv}, {1'b1, ~pads});
    host_u.shift(1'b1, 8, {56'h0, dap_pkg::IR_BYPASS, dap_pkg::IR_DBG}, q);
    n = dbg_cnt;
    host_u.shift(1'b0, 2, 64'h0, q);
    tick(8);
    check("debug access", dbg_cnt - n, 1);
    tick(1);
    oen = 1'b1;
    tick(4);
    check("pin idle", pin, 1'b1);
    ce = 1'b0;
    bkpt = 1'b1;
    tick(2);
    check("pin frozen", pin, 1'b1);
    ce = 1'b1;
    tick(1);
    check("pin at break", pin, 1'b0);
    bkpt = 1'b0;
    tick(3);
    check("pin held", pin, 1'b0);
    sec[14] = 1'b1;
    tick(6);
    check("pin disabled", pin, 1'b1);
    bclr = 1'b1;
    sec[14] = 1'b0;
    tick(1);
    bclr = 1'b0;
    tick(3);
    check("pin cleared", pin, 1'b1);
    oen = 1'b0;
    ien = 1'b1;
    for (int s = 0; s < 2; s++) begin
      sec[14] = s[0];
      tick(8);
      n = dbg_cnt;
      ext_n = 1'b0;
      tick(10);
      ext_n = 1'b1;
      check("debug entry", dbg_cnt - n, s ? 0 : 1);
    end
    sec[0] = 1'b1;
    host_u.oe_seen = 0;
    host_u.treset();
    host_u.shift(1'b0, 64, 64'h0, q);
    check("scan off", host_u.oe_seen, 0);
    stop_test();
  end
endmodule

bind jtag_debug_access_port dap_assertions chk_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .pll_lock_i(pll_lock_i),
  .boot_start_o(boot_start_o), .booting_o(booting_o), .sec_reg_i(sec_reg_i), .tck_i(tck_i), .trst_n_i(trst_n_i),
  .tdo_oe_o(tdo_oe_o), .pad_drive_o(pad_drive_o), .pad_extest_o(pad_extest_o), .debug_n_oe_o(debug_n_oe_o),
  .dbg_out_en_i(dbg_out_en_i), .acc_o(acc_o));
